// ### rtl/wpi2c_dev.sv
// Purpose: Device end of the two-wire register port.
// Assumes: Core clock at least ten times the link bit rate.
// Notes: Byte logic runs on the link clock; start and stop are seen in the core.
`timescale 1ns/1ns

// Behaviour
// - Slave only, works at 100 and 400 kbps.
// - Answer only to seven-bit address 0x61.
// - Change data only while clock is low.
// - Data edges during clock high mark start, stop.
// - Master stops before starting, except repeated start.
// - Address, pointer high, pointer low, data, stop.
// - Sixteen-bit pointer selects register, then increments.
// - Master writes address, pointer, then data byte.
// - Acknowledge every byte received during writes.
// - Further written bytes go to following registers.
// - Read needs pointer write, repeated start, read address.
// - Acknowledge address and pointer, never returned data.
// - Master acknowledges to continue; not-acknowledge ends reading.
module wpi2c_dev
  import wpi2c_pkg::*;
(
  // Core clock and reset.
  input  wire logic        CLK_I,
  input  wire logic        RESET_I,
  // Two-wire link.
  wpi2c_if.dev             LK,
  // Register space access.
  output logic [15:0]      REG_ADDR_O,
  output logic [7:0]       REG_WDATA_O,
  output logic             REG_WR_O,
  output logic             REG_RD_O,
  input  wire logic [7:0]  REG_RDATA_I,
  // Link status.
  output logic             LINK_BUSY_O
);
  // Core domain.
  logic          rst_q;
  logic          frame_rst_q;
  logic          scl_p_q;
  logic          sda_p_q;
  logic          wr_p_q;
  logic          rd_p_q;
  logic          rd_cap_q;
  logic [7:0]    rd_hold_q;
  logic [3:0]    raw_w;
  logic [3:0]    syn_w;
  logic          scl_s;
  logic          sda_s;
  logic          wr_s;
  logic          rd_s;
  logic          wr_ev_w;
  logic          rd_ev_w;
  // Link domain.
  wpi2c_dstate_t st_q;
  logic [3:0]    cnt_q;
  logic [6:0]    sh_q;
  logic          ack_q;
  logic [15:0]   ptr_q;
  logic [15:0]   xfer_addr_q;
  logic [7:0]    wr_byte_q;
  logic          wr_tog_q;
  logic          rd_tog_q;
  logic          sda_oe_q;
  logic [7:0]    byte_w;
  logic          addr_hit_w;
  logic          more_w;

  assign byte_w     = {sh_q, LK.sda};
  assign addr_hit_w = (byte_w[7:1] == SLV_ADDR);
  assign more_w     = (cnt_q == ACK_SLOT) && (st_q == DS_RDATA) && !ack_q && !LK.sda;

  // Pins and toggles from the link domain pass two flip-flops.
  assign raw_w = {rd_tog_q, wr_tog_q, LK.sda, LK.scl};
  for (genvar i = 0; i < 4; i++) begin : g_sync
    wpi2c_sync u_sync (
      .clk_i (CLK_I),
      .rst_i (RESET_I),
      .d_i   (raw_w[i]),
      .q_o   (syn_w[i])
    );
  end
  assign scl_s   = syn_w[0];
  assign sda_s   = syn_w[1];
  assign wr_s    = syn_w[2];
  assign rd_s    = syn_w[3];
  assign wr_ev_w = wr_s ^ wr_p_q;
  assign rd_ev_w = rd_s ^ rd_p_q;

  // Registered copy of reset that clears the pointer in the link domain.
  always_ff @(posedge CLK_I) begin
    rst_q <= RESET_I;
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      scl_p_q     <= 1'b0;
      sda_p_q     <= 1'b0;
      frame_rst_q <= 1'b1;
    end else begin
      scl_p_q     <= scl_s;
      sda_p_q     <= sda_s;
      frame_rst_q <= scl_p_q & scl_s & (sda_p_q ^ sda_s);
    end
  end

  // Busy from a start until a stop.
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      LINK_BUSY_O <= 1'b0;
    end else if (scl_p_q & scl_s & sda_p_q & ~sda_s) begin
      LINK_BUSY_O <= 1'b1;
    end else if (scl_p_q & scl_s & ~sda_p_q & sda_s) begin
      LINK_BUSY_O <= 1'b0;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      wr_p_q      <= 1'b0;
      rd_p_q      <= 1'b0;
      REG_WR_O    <= 1'b0;
      REG_RD_O    <= 1'b0;
      REG_ADDR_O  <= 16'h0000;
      REG_WDATA_O <= 8'h00;
    end else begin
      wr_p_q   <= wr_s;
      rd_p_q   <= rd_s;
      REG_WR_O <= wr_ev_w;
      REG_RD_O <= rd_ev_w;
      if (wr_ev_w | rd_ev_w) begin
        REG_ADDR_O <= xfer_addr_q;
      end
      if (wr_ev_w) begin
        REG_WDATA_O <= wr_byte_q;
      end
    end
  end

  // Read data is taken one cycle after the read strobe.
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      rd_cap_q  <= 1'b0;
      rd_hold_q <= 8'h00;
    end else begin
      rd_cap_q <= REG_RD_O;
      if (rd_cap_q) begin
        rd_hold_q <= REG_RDATA_I;
      end
    end
  end

  always_ff @(posedge LK.scl or posedge frame_rst_q) begin
    if (frame_rst_q) begin
      st_q  <= DS_ADDR;
      cnt_q <= 4'h0;
      sh_q  <= 7'h00;
      ack_q <= 1'b0;
    end else if (cnt_q == ACK_SLOT) begin
      cnt_q <= 4'h0;
      if ((st_q == DS_RDATA) && !ack_q && LK.sda) begin
        st_q <= DS_IGNORE;
      end
    end else begin
      cnt_q <= cnt_q + 4'h1;
      sh_q  <= byte_w[6:0];
      if (cnt_q == LAST_BIT) begin
        unique case (st_q)
          DS_ADDR: begin
            ack_q <= addr_hit_w;
            if (!addr_hit_w) begin
              st_q <= DS_IGNORE;
            end else if (byte_w[0]) begin
              st_q <= DS_RDATA;
            end else begin
              st_q <= DS_PTRH;
            end
          end
          DS_PTRH: begin
            ack_q <= 1'b1;
            st_q  <= DS_PTRL;
          end
          DS_PTRL: begin
            ack_q <= 1'b1;
            st_q  <= DS_WDATA;
          end
          DS_WDATA: begin
            ack_q <= 1'b1;
          end
          DS_RDATA: begin
            ack_q <= 1'b0;
          end
          DS_IGNORE: begin
            ack_q <= 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge LK.scl or posedge rst_q) begin
    if (rst_q) begin
      ptr_q       <= 16'h0000;
      xfer_addr_q <= 16'h0000;
      wr_byte_q   <= 8'h00;
      wr_tog_q    <= 1'b0;
      rd_tog_q    <= 1'b0;
    end else if (cnt_q == LAST_BIT) begin
      if (st_q == DS_PTRH) begin
        ptr_q[15:8] <= byte_w;
      end
      if (st_q == DS_PTRL) begin
        ptr_q[7:0] <= byte_w;
      end
      if (st_q == DS_WDATA) begin
        xfer_addr_q <= ptr_q;
        wr_byte_q   <= byte_w;
        wr_tog_q    <= ~wr_tog_q;
        ptr_q       <= ptr_q + 16'h0001;
      end
      if ((st_q == DS_ADDR) && addr_hit_w && byte_w[0]) begin
        xfer_addr_q <= ptr_q;
        rd_tog_q    <= ~rd_tog_q;
        ptr_q       <= ptr_q + 16'h0001;
      end
    end else if (more_w) begin
      xfer_addr_q <= ptr_q;
      rd_tog_q    <= ~rd_tog_q;
      ptr_q       <= ptr_q + 16'h0001;
    end
  end

  always_ff @(negedge LK.scl or posedge frame_rst_q) begin
    if (frame_rst_q) begin
      sda_oe_q <= 1'b0;
    end else if (cnt_q == ACK_SLOT) begin
      sda_oe_q <= ack_q;
    end else if (st_q == DS_RDATA) begin
      sda_oe_q <= ~rd_hold_q[3'(LAST_BIT - cnt_q)];
    end else begin
      sda_oe_q <= 1'b0;
    end
  end

  assign LK.sda_d_o  = 1'b0;
  assign LK.sda_d_oe = sda_oe_q;
endmodule : wpi2c_dev

// ### rtl/wpi2c_host.sv
// Purpose: Host end that runs register transactions on the two-wire link.
// Assumes: Single master; the device never stretches the clock.
// Notes: Clock is divided from the core clock in quarter-bit steps.
`timescale 1ns/1ns
module wpi2c_host
  import wpi2c_pkg::*;
(
  // Core clock and reset.
  input  wire logic        CLK_I,
  input  wire logic        RESET_I,
  // Two-wire link.
  wpi2c_if.host            LK,
  // Command.
  input  wire logic        CMD_VALID_I,
  output logic             CMD_READY_O,
  input  wire logic        CMD_RD_I,
  input  wire logic        CMD_FAST_I,
  input  wire logic [15:0] CMD_PTR_I,
  input  wire logic [7:0]  CMD_LEN_I,
  // Write data.
  input  wire logic [7:0]  WR_DATA_I,
  output logic             WR_TAKE_O,
  // Read data and status.
  output logic [7:0]       RD_DATA_O,
  output logic             RD_VALID_O,
  output logic             NACK_O
);
  wpi2c_hstate_t st_q;
  logic [5:0]    div_q;
  logic [5:0]    qtr_q;
  logic [1:0]    qt_q;
  logic [3:0]    bit_q;
  logic [1:0]    ph_q;
  logic          rd_q;
  logic          rdir_q;
  logic [7:0]    left_q;
  logic [15:0]   ptr_q;
  logic [7:0]    sh_q;
  logic [7:0]    rx_q;
  logic          ackn_q;
  logic          scl_q;
  logic          sda_lo_q;
  logic          scl_oe_q;
  logic          sda_s;
  logic          tick_w;
  logic          rxb_w;

  assign tick_w = (div_q == 6'h00);
  assign rxb_w  = rd_q & rdir_q & (ph_q == PH_DATA);

  wpi2c_sync u_sda_sync (
    .clk_i (CLK_I),
    .rst_i (RESET_I),
    .d_i   (LK.sda),
    .q_o   (sda_s)
  );

  always_ff @(posedge CLK_I) begin
    if (RESET_I || (st_q == HS_IDLE)) begin
      div_q <= 6'h00;
    end else begin
      div_q <= tick_w ? qtr_q - 6'h01 : div_q - 6'h01;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      st_q <= HS_IDLE;
      qtr_q <= QTR_FAST_CYC;
      qt_q <= QT_DRIVE;
      bit_q <= 4'h0;
      ph_q <= PH_ADDR;
      rd_q <= 1'b0;
      rdir_q <= 1'b0;
      left_q <= 8'h00;
      ptr_q <= 16'h0000;
      sh_q <= 8'h00;
      rx_q <= 8'h00;
      ackn_q <= 1'b0;
      scl_q <= 1'b1;
      sda_lo_q <= 1'b0;
      CMD_READY_O <= 1'b1;
      WR_TAKE_O <= 1'b0;
      RD_DATA_O <= 8'h00;
      RD_VALID_O <= 1'b0;
      NACK_O <= 1'b0;
    end else begin
      WR_TAKE_O  <= 1'b0;
      RD_VALID_O <= 1'b0;
      NACK_O     <= 1'b0;
      if (st_q == HS_IDLE) begin
        if (CMD_VALID_I) begin
          CMD_READY_O <= 1'b0;
          st_q <= HS_START;
          qtr_q <= CMD_FAST_I ? QTR_FAST_CYC : QTR_STD_CYC;
          qt_q <= QT_DRIVE;
          ph_q <= PH_ADDR;
          rd_q <= CMD_RD_I;
          rdir_q <= 1'b0;
          left_q <= CMD_LEN_I;
          ptr_q <= CMD_PTR_I;
          sh_q <= {SLV_ADDR, 1'b0};
        end
      end else if (tick_w) begin
        qt_q <= qt_q + 2'h1;
        unique case (st_q)
          HS_START: begin
            if (qt_q == QT_RISE) sda_lo_q <= 1'b1;
            if (qt_q == QT_FALL) begin
              scl_q <= 1'b0;
              st_q <= HS_BIT;
              bit_q <= 4'h0;
            end
          end
          HS_RSTART: begin
            if (qt_q == QT_DRIVE) sda_lo_q <= 1'b0;
            if (qt_q == QT_RISE) scl_q <= 1'b1;
            if (qt_q == QT_MID) sda_lo_q <= 1'b1;
            if (qt_q == QT_FALL) begin
              scl_q <= 1'b0;
              st_q <= HS_BIT;
              bit_q <= 4'h0;
              rdir_q <= 1'b1;
              ph_q <= PH_ADDR;
              sh_q <= {SLV_ADDR, 1'b1};
            end
          end
          HS_STOP: begin
            if (qt_q == QT_DRIVE) sda_lo_q <= 1'b1;
            if (qt_q == QT_RISE) scl_q <= 1'b1;
            if (qt_q == QT_MID) sda_lo_q <= 1'b0;
            if (qt_q == QT_FALL) begin
              st_q <= HS_IDLE;
              CMD_READY_O <= 1'b1;
            end
          end
          HS_BIT: begin
            if (qt_q == QT_DRIVE) begin
              if (rxb_w) sda_lo_q <= (bit_q == ACK_SLOT) && (left_q != 8'h00);
              else sda_lo_q <= (bit_q != ACK_SLOT) && !sh_q[7];
            end
            if (qt_q == QT_RISE) scl_q <= 1'b1;
            if (qt_q == QT_MID) begin
              if (bit_q == ACK_SLOT) ackn_q <= sda_s;
              else rx_q <= {rx_q[6:0], sda_s};
            end
            if (qt_q == QT_FALL) begin
              scl_q <= 1'b0;
              if (bit_q != ACK_SLOT) begin
                bit_q <= bit_q + 4'h1;
                sh_q <= {sh_q[6:0], 1'b0};
              end else begin
                bit_q <= 4'h0;
                if (rxb_w) begin
                  RD_DATA_O <= rx_q;
                  RD_VALID_O <= 1'b1;
                  if (left_q == 8'h00) st_q <= HS_STOP;
                  else left_q <= left_q - 8'h01;
                end else if (ackn_q) begin
                  NACK_O <= 1'b1;
                  st_q <= HS_STOP;
                end else begin
                  unique case (ph_q)
                    PH_ADDR: begin
                      ph_q <= rdir_q ? PH_DATA : PH_PTRH;
                      sh_q <= ptr_q[15:8];
                    end
                    PH_PTRH: begin
                      ph_q <= PH_PTRL;
                      sh_q <= ptr_q[7:0];
                    end
                    PH_PTRL: begin
                      if (rd_q) begin
                        st_q <= HS_RSTART;
                      end else begin
                        ph_q <= PH_DATA;
                        sh_q <= WR_DATA_I;
                        WR_TAKE_O <= 1'b1;
                      end
                    end
                    PH_DATA: begin
                      if (left_q == 8'h00) begin
                        st_q <= HS_STOP;
                      end else begin
                        left_q <= left_q - 8'h01;
                        sh_q <= WR_DATA_I;
                        WR_TAKE_O <= 1'b1;
                      end
                    end
                  endcase
                end
              end
            end
          end
          HS_IDLE: begin
          end
        endcase
      end
    end
  end

  // The clock pull is registered so that the pin comes straight from a flop.
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      scl_oe_q <= 1'b0;
    end else begin
      scl_oe_q <= ~scl_q;
    end
  end

  assign LK.scl_h_o  = 1'b0;
  assign LK.scl_h_oe = scl_oe_q;
  assign LK.sda_h_o  = 1'b0;
  assign LK.sda_h_oe = sda_lo_q;
endmodule : wpi2c_host

// ### rtl/wpi2c_if.sv
// Purpose: Two-wire link between the host end and the device end.
// Assumes: Both lines are open drain with pull-ups.
// Notes: An enabled driver pulls its line low; otherwise the line reads high.
`timescale 1ns/1ns
interface wpi2c_if;
  logic scl_h_o;
  logic scl_h_oe;
  logic sda_h_o;
  logic sda_h_oe;
  logic sda_d_o;
  logic sda_d_oe;
  logic scl;
  logic sda;

  assign scl = ~(scl_h_oe & ~scl_h_o);
  assign sda = ~((sda_h_oe & ~sda_h_o) | (sda_d_oe & ~sda_d_o));

  modport dev (input scl, input sda, output sda_d_o, output sda_d_oe);
  modport host (input scl, input sda, output scl_h_o, output scl_h_oe,
                output sda_h_o, output sda_h_oe);
endinterface : wpi2c_if

// ### rtl/wpi2c_pkg.sv
// Purpose: Shared constants and types of the two-wire register port.
// Assumes: A 25 MHz core clock on both ends.
// Notes: Used by the device end, the host end, the link checker and the bench.
package wpi2c_pkg;
  localparam logic [6:0] SLV_ADDR      = 7'h61;
  localparam logic [3:0] LAST_BIT      = 4'h7;
  localparam logic [3:0] ACK_SLOT      = 4'h8;
  localparam int         CLK_PERIOD_NS = 40;
  localparam int         SCL_STD_NS    = 10000;
  localparam int         SCL_FAST_NS   = 2500;
  localparam logic [5:0] QTR_STD_CYC   =
    6'((SCL_STD_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [5:0] QTR_FAST_CYC  =
    6'((SCL_FAST_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [1:0] QT_DRIVE      = 2'h0;
  localparam logic [1:0] QT_RISE       = 2'h1;
  localparam logic [1:0] QT_MID        = 2'h2;
  localparam logic [1:0] QT_FALL       = 2'h3;
  localparam logic [1:0] PH_ADDR       = 2'h0;
  localparam logic [1:0] PH_PTRH       = 2'h1;
  localparam logic [1:0] PH_PTRL       = 2'h2;
  localparam logic [1:0] PH_DATA       = 2'h3;

  typedef enum logic [5:0] {
    DS_ADDR   = 6'h01,
    DS_PTRH   = 6'h02,
    DS_PTRL   = 6'h04,
    DS_WDATA  = 6'h08,
    DS_RDATA  = 6'h10,
    DS_IGNORE = 6'h20
  } wpi2c_dstate_t;

  typedef enum logic [4:0] {
    HS_IDLE   = 5'h01,
    HS_START  = 5'h02,
    HS_BIT    = 5'h04,
    HS_RSTART = 5'h08,
    HS_STOP   = 5'h10
  } wpi2c_hstate_t;
endpackage : wpi2c_pkg

// ### rtl/wpi2c_sync.sv
// Purpose: Two flip-flop synchroniser for one level.
// Assumes: The input may change at any time.
// Notes: Only the second stage is visible outside.
`timescale 1ns/1ns
module wpi2c_sync (
  // Clock and reset.
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Level in and out.
  input  wire logic d_i,
  output logic      q_o
);
  logic meta_q;
  logic sync_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;
endmodule : wpi2c_sync

// ### verification/testbench.sv
// Purpose: Self-checking bench for host and device ends facing each other.
// Assumes: Register space is modelled here; a second link is driven by hand.
// Notes: The host divides the link clock from the core clock.
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end
module testbench;
  import wpi2c_pkg::*;
  logic        clk, rst, cmd_v, cmd_rd, cmd_fast, rdy, wtake, rvld, nack;
  logic        r_wr, r_rd, busy, wr2, rd2, busy2;
  logic [15:0] cmd_ptr, r_addr;
  logic [7:0]  cmd_len, wdat, rdat, r_wdata, r_rdata;
  logic [7:0]  mem [logic [15:0]];
  logic [7:0]  wq[$], rq[$];
  logic [23:0] wlog[$];
  int          n_mismatch, checked, n_nack, n_bad2;

  wpi2c_if lk();
  wpi2c_if lk2();
  wpi2c_host wpi2c_host_i (.CLK_I(clk), .RESET_I(rst), .LK(lk), .CMD_VALID_I(cmd_v),
    .CMD_READY_O(rdy), .CMD_RD_I(cmd_rd), .CMD_FAST_I(cmd_fast), .CMD_PTR_I(cmd_ptr),
    .CMD_LEN_I(cmd_len), .WR_DATA_I(wdat), .WR_TAKE_O(wtake), .RD_DATA_O(rdat),
    .RD_VALID_O(rvld), .NACK_O(nack));
  wpi2c_dev wpi2c_dev_i (.CLK_I(clk), .RESET_I(rst), .LK(lk), .REG_ADDR_O(r_addr),
    .REG_WDATA_O(r_wdata), .REG_WR_O(r_wr), .REG_RD_O(r_rd), .REG_RDATA_I(r_rdata),
    .LINK_BUSY_O(busy));
  wpi2c_dev wpi2c_dev_i2 (.CLK_I(clk), .RESET_I(rst), .LK(lk2), .REG_ADDR_O(),
    .REG_WDATA_O(), .REG_WR_O(wr2), .REG_RD_O(rd2), .REG_RDATA_I(8'h00),
    .LINK_BUSY_O(busy2));
  wpi2c_chk wpi2c_chk_i (.CLK_I(clk), .RESET_I(rst), .scl(lk.scl), .sda(lk.sda),
    .scl_h_oe(lk.scl_h_oe), .sda_h_oe(lk.sda_h_oe), .sda_d_oe(lk.sda_d_oe));

  // Unwritten registers return a pattern tied to their address.
  function automatic logic [7:0] mem_at(input logic [15:0] a);
    return mem.exists(a) ? mem[a] : ~a[7:0];
  endfunction : mem_at

  // Strobes are sampled at the falling edge, in the middle of the cycle they stand in.
  always @(negedge clk) begin
    if (r_wr) begin
      mem[r_addr] = r_wdata;
      wlog.push_back({r_addr, r_wdata});
    end
    if (wr2 || rd2) n_bad2++;
    r_rdata <= mem_at(r_addr);
    if (wtake && wq.size() > 0) wdat <= wq.pop_front();
    if (rvld) rq.push_back(rdat);
    if (nack) n_nack++;
  end

  task automatic close_out();
    $display("Mismatches %0d, comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out

  task automatic run_cmd(input logic rd, fast, input logic [15:0] p, input logic [7:0] n);
    int k;
    k = 0;
    @(negedge clk);
    cmd_v = 1'b1;
    cmd_rd = rd;
    cmd_fast = fast;
    cmd_ptr = p;
    cmd_len = n;
    @(negedge clk);
    cmd_v = 1'b0;
    repeat (200) @(negedge clk);
    `CHK("busy", 1'b1, busy)
    while (rdy !== 1'b1 && k < 30000) begin
      @(negedge clk);
      k++;
    end
    `CHK("ready", 1'b1, rdy)
    repeat (8) @(negedge clk);
    `CHK("idle", 1'b0, busy)
    `CHK("nack", 0, n_nack)
  endtask : run_cmd

  task automatic do_write(input logic fast, input logic [15:0] p, input logic [7:0] d[$]);
    @(negedge clk);
    wq = d;
    wdat = wq.pop_front();
    wlog.delete();
    run_cmd(1'b0, fast, p, 8'(d.size() - 1));
    `CHK("wr count", d.size(), wlog.size())
    foreach (d[i]) `CHK("wr reg", {16'(p + i), d[i]}, wlog[i])
  endtask : do_write

  task automatic do_read(input logic fast, input logic [15:0] p, input logic [7:0] d[$]);
    rq.delete();
    run_cmd(1'b1, fast, p, 8'(d.size() - 1));
    `CHK("rd count", d.size(), rq.size())
    foreach (d[i]) `CHK("rd byte", d[i], rq[i])
  endtask : do_read

  task automatic t_page_write();
    do_write(1'b1, 16'hFFFE, '{8'hA1, 8'hB2, 8'hC3});
  endtask : t_page_write

  task automatic t_page_read();
    do_read(1'b0, 16'hFFFE, '{8'hA1, 8'hB2, 8'hC3});
  endtask : t_page_read

  task automatic t_single();
    do_write(1'b0, 16'h0612, '{8'h5C});
    do_read(1'b1, 16'h0612, '{8'h5C});
    do_read(1'b1, 16'h0613, '{8'hEC});
  endtask : t_single

  task automatic bb_bit(input logic b, output logic s);
    lk2.sda_h_oe = ~b;
    repeat (16) @(negedge clk);
    lk2.scl_h_oe = 1'b0;
    repeat (16) @(negedge clk);
    s = lk2.sda;
    repeat (16) @(negedge clk);
    lk2.scl_h_oe = 1'b1;
    repeat (16) @(negedge clk);
  endtask : bb_bit

  task automatic t_wrong_addr();
    logic        s;
    logic [17:0] v;
    v = {8'hC4, 1'b1, 8'h00, 1'b1};
    repeat (16) @(negedge clk);
    lk2.sda_h_oe = 1'b1;
    repeat (16) @(negedge clk);
    lk2.scl_h_oe = 1'b1;
    `CHK("busy2", 1'b1, busy2)
    for (int k = 17; k >= 0; k--) begin
      bb_bit(v[k], s);
      if (k == 9 || k == 0) `CHK("released", 1'b1, s)
    end
    lk2.sda_h_oe = 1'b1;
    repeat (16) @(negedge clk);
    lk2.scl_h_oe = 1'b0;
    repeat (16) @(negedge clk);
    lk2.sda_h_oe = 1'b0;
    repeat (16) @(negedge clk);
    `CHK("idle2", 1'b0, busy2)
    `CHK("strobes2", 0, n_bad2)
  endtask : t_wrong_addr

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    #2_500_000;
    n_mismatch++;
    close_out();
  end
  initial begin
    rst = 1'b1;
    {cmd_v, cmd_rd, cmd_fast, cmd_ptr, cmd_len, wdat, r_rdata} = '0;
    {lk2.scl_h_o, lk2.scl_h_oe, lk2.sda_h_o, lk2.sda_h_oe} = '0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    repeat (5) @(negedge clk);
    t_page_write();
    t_page_read();
    t_single();
    t_wrong_addr();
    close_out();
  end
endmodule : testbench

// ### verification/wpi2c_chk.sv
// Purpose: Protocol checks on the link between the host and device ends.
// Assumes: Both lines are sampled on the core clock.
// Notes: Bit and byte positions are rebuilt from the lines alone.
`timescale 1ns/1ns
module wpi2c_chk
  import wpi2c_pkg::*;
(
  // Core clock and reset.
  input wire logic CLK_I,
  input wire logic RESET_I,
  // Lines and pull enables.
  input wire logic scl,
  input wire logic sda,
  input wire logic scl_h_oe,
  input wire logic sda_h_oe,
  input wire logic sda_d_oe
);
  logic       scl_q, sda_q, busy_q, rd_q, ok_q, nack_q;
  logic       rise, start, stop, ack;
  logic [3:0] bit_q;
  logic [2:0] byte_q;
  logic [7:0] sh_q, hi_q;

  assign rise  = scl & ~scl_q;
  assign start = scl & scl_q & sda_q & ~sda;
  assign stop  = scl & scl_q & ~sda_q & sda;
  assign ack   = rise && bit_q == ACK_SLOT;

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);

  always_ff @(posedge CLK_I) begin
    scl_q <= RESET_I | scl;
    sda_q <= RESET_I | sda;
  end
  always_ff @(posedge CLK_I) begin
    if (RESET_I || stop) busy_q <= 1'b0;
    else if (start) busy_q <= 1'b1;
  end
  always_ff @(posedge CLK_I) begin
    if (RESET_I || start) begin
      bit_q  <= 4'h0;
      byte_q <= 3'h0;
    end else if (ack) begin
      bit_q  <= 4'h0;
      byte_q <= byte_q + {2'h0, ~&byte_q};
    end else if (rise) begin
      bit_q <= bit_q + 4'h1;
    end
  end
  always_ff @(posedge CLK_I) begin
    if (rise && bit_q != ACK_SLOT) sh_q <= {sh_q[6:0], sda};
  end
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      rd_q <= 1'b0;
      ok_q <= 1'b0;
    end else if (ack && byte_q == 3'h0) begin
      rd_q <= sh_q[0];
      ok_q <= sh_q[7:1] == SLV_ADDR;
    end
  end
  always_ff @(posedge CLK_I) begin
    if (RESET_I || start) nack_q <= 1'b0;
    else if (ack && byte_q != 3'h0 && rd_q && sda) nack_q <= 1'b1;
  end
  always_ff @(posedge CLK_I) begin
    if (RESET_I || !scl) hi_q <= 8'h00;
    else if (hi_q != 8'hFF) hi_q <= hi_q + 8'h01;
  end

  a_scl_high_min: assert property ($fell(scl) |-> hi_q >= 8'h0F)
    else $error("clock high time too short");
  a_addr_ack: assert property (ack && byte_q == 3'h0 && sh_q[7:1] == SLV_ADDR |-> !sda)
    else $error("own address not acknowledged");
  a_dev_change_low: assert property ($changed(sda_d_oe) |-> !scl)
    else $error("device changed data while clock high");
  a_host_change_low: assert property ($changed(sda_h_oe) && !scl_h_oe |-> (start || stop))
    else $error("host changed data while clock high");
  a_idle_lines_high: assert property (!busy_q && !start |-> scl && sda)
    else $error("line low while bus idle");
  a_rstart_only: assert property (start && busy_q |-> byte_q == 3'h3 && bit_q == 4'h1 && !rd_q)
    else $error("start inside a transaction outside read setup");
  a_write_ack: assert property (ack && byte_q != 3'h0 && ok_q && !rd_q |-> !sda)
    else $error("written byte not acknowledged");
  a_read_noack: assert property (ack && byte_q != 3'h0 && rd_q |-> !sda_d_oe)
    else $error("device drove acknowledge on returned data");
  a_nack_release: assert property (nack_q |-> !sda_d_oe)
    else $error("device drives after master not-acknowledge");
endmodule : wpi2c_chk
